// >>> timer16_wave_mode_control.sv
// Top of the 16-bit timer: byte bus registers, counter and two waveform pins.
//
// Functional notes
// - One high-byte latch shared by all 16-bit registers.
// - Latch keeps its value after low-byte write.
// - Nonzero output mode hands the pin to waveform unless 1101 or PWM mode 01 is off.
// - Pin driver enabled only by port direction bit.
// - Non-PWM: off, toggle, clear, set on match.
// - PWM mode 01: off, or toggle A when msb.
// - Fast PWM: match clears/sets, bottom does opposite.
// - Fast PWM: match at top ignored, bottom acts.
// - Dual slope: up-match and down-match act oppositely.
// - Wave select joins two control A, two control B bits.
// - Normal: top FFFF, immediate reload, flag at max.
// - Phase correct: tops, reload at top, flag bottom.
// - Clear-on-compare: top compare A or capture; 1101 reserved.
// - Fast PWM: tops, reload and flag at top.
// - Phase-frequency: top capture/compare A, events at bottom.
// - Low write loads both bytes; low read latches high.
// - Compare reads bypass the shared high-byte latch.
`timescale 1ns/1ns
module timer16_wave_mode_control
  import timer16_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [5:0] ioAddr,
  input  wire logic [7:0] ioWrData,
  input  wire logic       ioWrite,
  input  wire logic       ioRead,
  output logic      [7:0] ioRdData,
  input  wire logic       portOutA,
  input  wire logic       portDirA,
  input  wire logic       portOutB,
  input  wire logic       portDirB,
  output logic            pinOutA,
  output logic            pinOeA,
  output logic            pinOutB,
  output logic            pinOeB,
  output logic            waveOutA,
  output logic            waveOutB,
  output logic            overflowFlag
);

  typedef struct packed {
    logic [7:0]       ctrlA;
    logic [7:0]       ctrlB;
    logic [15:0]      count;
    logic             countDown;
    logic [1:0][15:0] cmp;
    logic [1:0][15:0] cmpBuf;
    logic [15:0]      capture;
    logic [7:0]       tempHigh;
    logic             ovf;
    logic             blockMatch;
    logic [1:0]       level;
    logic [7:0]       rdData;
    logic [1:0]       pinOut;
    logic [1:0]       pinOe;
  } state_t;

  state_t     s_reg;
  state_t     s_next;
  logic [3:0] waveSelect;
  wave_kind_t waveKind;
  logic [15:0] topValue;
  point_t     reloadPoint;
  point_t     flagPoint;
  logic       running;
  logic       dualSlope;
  logic       atTop;
  logic       atBottom;
  logic       atMax;
  logic       reservedMode;
  logic [1:0] outMode [2];
  logic [1:0] matchHit;
  logic [1:0] matchAtTop;
  logic [1:0] levelNext;
  logic [1:0] connected;
  logic [1:0] portOutVec;
  logic [1:0] portDirVec;

  assign waveSelect = {s_reg.ctrlB[WAVE_HI_POS +: 2], s_reg.ctrlA[WAVE_LO_POS +: 2]};
  assign reservedMode = (waveSelect == 4'hD);
  assign outMode[0] = s_reg.ctrlA[OUT_MODE_A_POS +: 2];
  assign outMode[1] = s_reg.ctrlA[OUT_MODE_B_POS +: 2];
  assign portOutVec = {portOutB, portOutA};
  assign portDirVec = {portDirB, portDirA};

  // Any nonzero clock select runs the counter at the full clock rate.
  assign running   = (s_reg.ctrlB[CLK_SEL_POS +: 3] != 3'h0);
  assign dualSlope = (waveKind == KIND_PHASE) || (waveKind == KIND_FREQ);
  assign atTop     = (s_reg.count == topValue);
  assign atBottom  = (s_reg.count == BOTTOM);
  assign atMax     = (s_reg.count == TOP_MAX);

  wave_mode_decode u_decode (
    .waveSelect   (waveSelect),
    .compareA     (s_reg.cmp[0]),
    .captureValue (s_reg.capture),
    .waveKind     (waveKind),
    .topValue     (topValue),
    .reloadPoint  (reloadPoint),
    .flagPoint    (flagPoint)
  );

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      // A write to the counter suppresses the match on the following tick.
      assign matchHit[ch]   = running && !s_reg.blockMatch && (s_reg.count == s_reg.cmp[ch]);
      assign matchAtTop[ch] = (s_reg.cmp[ch] == topValue);
      wave_output_unit u_out (
        .waveKind     (waveKind),
        .outMode      (outMode[ch]),
        .selMsb       (waveSelect[3]),
        .isChanA      (ch == 0),
        .reservedMode (reservedMode),
        .matchHit     (matchHit[ch]),
        .matchAtTop   (matchAtTop[ch]),
        .bottomHit    (running && atBottom),
        .countUp      (!s_reg.countDown),
        .levelNow     (s_reg.level[ch]),
        .levelNext    (levelNext[ch]),
        .connected    (connected[ch])
      );
    end
  endgenerate

  always_comb begin
    logic flagHit;
    logic reloadHit;
    logic [15:0] wordIn;
    flagHit   = 1'b0;
    reloadHit = 1'b0;
    wordIn    = {s_reg.tempHigh, ioWrData};
    s_next    = s_reg;
    s_next.rdData = BYTE_RESET;

    if (running) begin
      s_next.blockMatch = 1'b0;
      if (!dualSlope) begin
        s_next.countDown = 1'b0;
        s_next.count = atTop ? BOTTOM : 16'(s_reg.count + COUNT_ONE);
      end else if (!s_reg.countDown) begin
        if (atTop && !atBottom) begin
          s_next.countDown = 1'b1;
          s_next.count = 16'(s_reg.count - COUNT_ONE);
        end else begin
          s_next.count = 16'(s_reg.count + COUNT_ONE);
        end
      end else if (atBottom) begin
        s_next.countDown = 1'b0;
        s_next.count = 16'(s_reg.count + COUNT_ONE);
      end else begin
        s_next.count = 16'(s_reg.count - COUNT_ONE);
      end
      case (flagPoint)
        AT_MAX:    flagHit = atMax;
        AT_TOP:    flagHit = atTop;
        AT_BOTTOM: flagHit = atBottom;
        default:   flagHit = 1'b0;
      endcase
      case (reloadPoint)
        AT_TOP:    reloadHit = atTop;
        AT_BOTTOM: reloadHit = atBottom;
        default:   reloadHit = 1'b0;
      endcase
    end
    if (reloadHit) begin
      s_next.cmp = s_reg.cmpBuf;
    end
    s_next.level = levelNext;

    if (ioWrite) begin
      if (ioAddr == ADDR_CTRL_A) begin
        s_next.ctrlA = ioWrData & CTRL_A_MASK;
      end else if (ioAddr == ADDR_CTRL_B) begin
        s_next.ctrlB = ioWrData & CTRL_B_MASK;
      end else if (ioAddr == ADDR_CNT_H || ioAddr == ADDR_CMPA_H ||
                   ioAddr == ADDR_CMPB_H || ioAddr == ADDR_CAP_H) begin
        s_next.tempHigh = ioWrData;
      end else if (ioAddr == ADDR_CNT_L) begin
        s_next.count = wordIn;
        s_next.blockMatch = 1'b1;
      end else if (ioAddr == ADDR_CMPA_L) begin
        s_next.cmpBuf[0] = wordIn;
        if (reloadPoint == AT_NONE) begin
          s_next.cmp[0] = wordIn;
        end
      end else if (ioAddr == ADDR_CMPB_L) begin
        s_next.cmpBuf[1] = wordIn;
        if (reloadPoint == AT_NONE) begin
          s_next.cmp[1] = wordIn;
        end
      end else if (ioAddr == ADDR_CAP_L) begin
        s_next.capture = wordIn;
      end else if (ioAddr == ADDR_FLAGS) begin
        if (ioWrData[OVF_POS]) begin
          s_next.ovf = 1'b0;
        end
      end
    end
    // Setting after the clear lets a same-cycle event survive the clear.
    if (flagHit) begin
      s_next.ovf = 1'b1;
    end

    if (ioRead) begin
      if (ioAddr == ADDR_CTRL_A) begin
        s_next.rdData = s_reg.ctrlA;
      end else if (ioAddr == ADDR_CTRL_B) begin
        s_next.rdData = s_reg.ctrlB;
      end else if (ioAddr == ADDR_CNT_L) begin
        s_next.rdData = s_reg.count[7:0];
        s_next.tempHigh = s_reg.count[15:8];
      end else if (ioAddr == ADDR_CAP_L) begin
        s_next.rdData = s_reg.capture[7:0];
        s_next.tempHigh = s_reg.capture[15:8];
      end else if (ioAddr == ADDR_CNT_H || ioAddr == ADDR_CAP_H) begin
        s_next.rdData = s_reg.tempHigh;
      end else if (ioAddr == ADDR_CMPA_L) begin
        s_next.rdData = s_reg.cmpBuf[0][7:0];
      end else if (ioAddr == ADDR_CMPA_H) begin
        s_next.rdData = s_reg.cmpBuf[0][15:8];
      end else if (ioAddr == ADDR_CMPB_L) begin
        s_next.rdData = s_reg.cmpBuf[1][7:0];
      end else if (ioAddr == ADDR_CMPB_H) begin
        s_next.rdData = s_reg.cmpBuf[1][15:8];
      end else if (ioAddr == ADDR_FLAGS) begin
        s_next.rdData = {7'h00, s_reg.ovf};
      end
    end

    for (int i = 0; i < 2; i++) begin
      s_next.pinOut[i] = connected[i] ? levelNext[i] : portOutVec[i];
      s_next.pinOe[i]  = portDirVec[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg.ctrlA      <= CTRL_A_RESET;
      s_reg.ctrlB      <= CTRL_B_RESET;
      s_reg.count      <= REG16_RESET;
      s_reg.countDown  <= 1'b0;
      s_reg.cmp        <= {REG16_RESET, REG16_RESET};
      s_reg.cmpBuf     <= {REG16_RESET, REG16_RESET};
      s_reg.capture    <= REG16_RESET;
      s_reg.tempHigh   <= BYTE_RESET;
      s_reg.ovf        <= 1'b0;
      s_reg.blockMatch <= 1'b0;
      s_reg.level      <= 2'h0;
      s_reg.rdData     <= BYTE_RESET;
      s_reg.pinOut     <= 2'h0;
      s_reg.pinOe      <= 2'h0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ioRdData     = s_reg.rdData;
  assign pinOutA      = s_reg.pinOut[0];
  assign pinOeA       = s_reg.pinOe[0];
  assign pinOutB      = s_reg.pinOut[1];
  assign pinOeB       = s_reg.pinOe[1];
  assign waveOutA     = s_reg.level[0];
  assign waveOutB     = s_reg.level[1];
  assign overflowFlag = s_reg.ovf;

endmodule

// >>> timer16_pkg.sv
// Shared constants and types for the 16-bit timer wave-mode control block.
package timer16_pkg;

  localparam logic [5:0] ADDR_CTRL_A = 6'h2F;
  localparam logic [5:0] ADDR_CTRL_B = 6'h23;
  localparam logic [5:0] ADDR_CNT_L  = 6'h2C;
  localparam logic [5:0] ADDR_CNT_H  = 6'h2D;
  localparam logic [5:0] ADDR_CMPA_L = 6'h2A;
  localparam logic [5:0] ADDR_CMPA_H = 6'h2B;
  localparam logic [5:0] ADDR_CMPB_L = 6'h28;
  localparam logic [5:0] ADDR_CMPB_H = 6'h29;
  localparam logic [5:0] ADDR_CAP_L  = 6'h24;
  localparam logic [5:0] ADDR_CAP_H  = 6'h25;
  localparam logic [5:0] ADDR_FLAGS  = 6'h2E;

  localparam int OUT_MODE_A_POS = 6;
  localparam int OUT_MODE_B_POS = 4;
  localparam int WAVE_LO_POS    = 0;
  localparam int WAVE_HI_POS    = 3;
  localparam int CLK_SEL_POS    = 0;
  localparam int OVF_POS        = 0;

  localparam logic [7:0] CTRL_A_MASK  = 8'hF3;
  localparam logic [7:0] CTRL_B_MASK  = 8'hDF;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [15:0] REG16_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET   = 8'h00;

  localparam logic [15:0] TOP_MAX   = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] BOTTOM    = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  localparam logic [3:0] WS_NORMAL   = 4'h0;
  localparam logic [3:0] WS_PC8      = 4'h1;
  localparam logic [3:0] WS_PC9      = 4'h2;
  localparam logic [3:0] WS_PC10     = 4'h3;
  localparam logic [3:0] WS_CLR_CMP  = 4'h4;
  localparam logic [3:0] WS_FAST8    = 4'h5;
  localparam logic [3:0] WS_FAST9    = 4'h6;
  localparam logic [3:0] WS_FAST10   = 4'h7;
  localparam logic [3:0] WS_PFC_CAP  = 4'h8;
  localparam logic [3:0] WS_PFC_CMP  = 4'h9;
  localparam logic [3:0] WS_PC_CAP   = 4'hA;
  localparam logic [3:0] WS_PC_CMP   = 4'hB;
  localparam logic [3:0] WS_CLR_CAP  = 4'hC;
  localparam logic [3:0] WS_FAST_CAP = 4'hE;
  localparam logic [3:0] WS_FAST_CMP = 4'hF;

  localparam logic [1:0] OM_OFF    = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR  = 2'h2;
  localparam logic [1:0] OM_SET    = 2'h3;

  typedef enum logic [1:0] {KIND_PLAIN, KIND_FAST, KIND_PHASE, KIND_FREQ} wave_kind_t;
  typedef enum logic [1:0] {AT_NONE, AT_MAX, AT_TOP, AT_BOTTOM} point_t;

endpackage

// >>> wave_mode_decode.sv
// Decodes the wave-select value into count style, top value and event points.
`timescale 1ns/1ns
module wave_mode_decode
  import timer16_pkg::*;
(
  input  wire logic [3:0]  waveSelect,
  input  wire logic [15:0] compareA,
  input  wire logic [15:0] captureValue,
  output wave_kind_t       waveKind,
  output logic [15:0]      topValue,
  output point_t           reloadPoint,
  output point_t           flagPoint
);

  always_comb begin
    waveKind    = KIND_PLAIN;
    topValue    = TOP_MAX;
    reloadPoint = AT_NONE;
    flagPoint   = AT_MAX;
    case (waveSelect)
      WS_NORMAL: begin
        topValue = TOP_MAX;
      end
      WS_PC8, WS_PC9, WS_PC10, WS_PC_CAP, WS_PC_CMP: begin
        waveKind    = KIND_PHASE;
        reloadPoint = AT_TOP;
        flagPoint   = AT_BOTTOM;
        if (waveSelect == WS_PC8) begin
          topValue = TOP_8BIT;
        end else if (waveSelect == WS_PC9) begin
          topValue = TOP_9BIT;
        end else if (waveSelect == WS_PC10) begin
          topValue = TOP_10BIT;
        end else if (waveSelect == WS_PC_CAP) begin
          topValue = captureValue;
        end else begin
          topValue = compareA;
        end
      end
      WS_CLR_CMP: begin
        topValue = compareA;
      end
      WS_CLR_CAP: begin
        topValue = captureValue;
      end
      WS_FAST8, WS_FAST9, WS_FAST10, WS_FAST_CAP, WS_FAST_CMP: begin
        waveKind    = KIND_FAST;
        reloadPoint = AT_TOP;
        flagPoint   = AT_TOP;
        if (waveSelect == WS_FAST8) begin
          topValue = TOP_8BIT;
        end else if (waveSelect == WS_FAST9) begin
          topValue = TOP_9BIT;
        end else if (waveSelect == WS_FAST10) begin
          topValue = TOP_10BIT;
        end else if (waveSelect == WS_FAST_CAP) begin
          topValue = captureValue;
        end else begin
          topValue = compareA;
        end
      end
      WS_PFC_CAP, WS_PFC_CMP: begin
        waveKind    = KIND_FREQ;
        reloadPoint = AT_BOTTOM;
        flagPoint   = AT_BOTTOM;
        topValue    = (waveSelect == WS_PFC_CAP) ? captureValue : compareA;
      end
      default: begin
        // The reserved code counts like normal mode but never drives a pin.
        flagPoint = AT_NONE;
      end
    endcase
  end

endmodule

// >>> wave_output_unit.sv
// Next waveform level and pin takeover for one compare channel.
`timescale 1ns/1ns
module wave_output_unit
  import timer16_pkg::*;
(
  input  wave_kind_t       waveKind,
  input  wire logic [1:0]  outMode,
  input  wire logic        selMsb,
  input  wire logic        isChanA,
  input  wire logic        reservedMode,
  input  wire logic        matchHit,
  input  wire logic        matchAtTop,
  input  wire logic        bottomHit,
  input  wire logic        countUp,
  input  wire logic        levelNow,
  output logic             levelNext,
  output logic             connected
);

  logic pwmToggle;

  always_comb begin
    pwmToggle = (outMode == OM_TOGGLE) && selMsb && isChanA;
    levelNext = levelNow;
    connected = 1'b0;
    if (waveKind == KIND_PLAIN) begin
      connected = (outMode != OM_OFF) && !reservedMode;
      if (matchHit && connected) begin
        case (outMode)
          OM_TOGGLE: levelNext = ~levelNow;
          OM_CLEAR:  levelNext = 1'b0;
          OM_SET:    levelNext = 1'b1;
          default:   levelNext = levelNow;
        endcase
      end
    end else begin
      connected = outMode[1] || pwmToggle;
      if (outMode[1] && waveKind == KIND_FAST) begin
        // A match in the bottom cycle wins, so the pin holds the match level.
        if (matchHit && !matchAtTop) begin
          levelNext = outMode[0];
        end else if (bottomHit) begin
          levelNext = ~outMode[0];
        end
      end else if (outMode[1]) begin
        if (matchHit) begin
          levelNext = countUp ? outMode[0] : ~outMode[0];
        end
      end else if (pwmToggle && matchHit) begin
        levelNext = ~levelNow;
      end
    end
  end

endmodule

// >>> cpu_bus_model.sv
// CPU-side bus master model: byte accesses and ordered 16-bit transfers.
`timescale 1ns/1ns
module cpu_bus_model (
  input  wire logic       clk,
  output logic      [5:0] ioAddr,
  output logic      [7:0] ioWrData,
  output logic            ioWrite,
  output logic            ioRead,
  input  wire logic [7:0] ioRdData
);
  initial begin
    ioAddr = 6'h3F;
    ioWrData = 8'hA5;
    ioWrite = 1'b0;
    ioRead = 1'b0;
  end

  // Idle address and data carry the inverse of the last value, so nothing stale can match.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    ioAddr = a;
    ioWrData = d;
    ioWrite = 1'b1;
    @(negedge clk);
    ioWrite = 1'b0;
    ioAddr = ~a;
    ioWrData = ~d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    ioAddr = a;
    ioRead = 1'b1;
    @(negedge clk);
    ioRead = 1'b0;
    ioAddr = ~a;
    d = ioRdData;
  endtask

  // High byte first; callers keep other latch users out of the pair.
  task automatic wr16(input logic [5:0] aLo, input logic [15:0] v);
    wr(aLo + 6'h01, v[15:8]);
    wr(aLo, v[7:0]);
  endtask

  // Low byte first, so the latch holds the matching high byte.
  task automatic rd16(input logic [5:0] aLo, output logic [15:0] v);
    rd(aLo, v[7:0]);
    rd(aLo + 6'h01, v[15:8]);
  endtask
endmodule

// >>> timer16_wave_chk.sv
// Concurrent checks on the timer top ports: control readback and pin takeover.
`timescale 1ns/1ns
module timer16_wave_chk
  import timer16_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [5:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic       ioWrite,
  input wire logic       ioRead,
  input wire logic [7:0] ioRdData,
  input wire logic       portOutA,
  input wire logic       portDirA,
  input wire logic       portOutB,
  input wire logic       portDirB,
  input wire logic       pinOutA,
  input wire logic       pinOeA,
  input wire logic       pinOutB,
  input wire logic       pinOeB,
  input wire logic       waveOutA,
  input wire logic       waveOutB,
  input wire logic       overflowFlag
);
  typedef struct packed {
    logic [7:0] ctrlA;
    logic [7:0] ctrlB;
    logic [1:0] settle;
  } shadow_t;
  shadow_t    shReg;
  shadow_t    shNext;
  logic [3:0] ws;
  logic       pwm;
  logic       connA;
  logic       connB;
  logic       settled;

  // Shadow copies of the control bytes let pin ownership be predicted from the bus alone.
  always_comb begin
    shNext = shReg;
    if (ioWrite && ioAddr == ADDR_CTRL_A) begin
      shNext.ctrlA = ioWrData & CTRL_A_MASK;
    end
    if (ioWrite && ioAddr == ADDR_CTRL_B) begin
      shNext.ctrlB = ioWrData & CTRL_B_MASK;
    end
    if (shReg.settle != 2'h3) begin
      shNext.settle = shReg.settle + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shReg <= '0;
    end else begin
      shReg <= shNext;
    end
  end

  assign settled = shReg.settle == 2'h3;
  assign ws = {shReg.ctrlB[4:3], shReg.ctrlA[1:0]};
  assign pwm = !(ws inside {WS_NORMAL, WS_CLR_CMP, WS_CLR_CAP, 4'hD});
  assign connA = shReg.ctrlA[7:6] != OM_OFF && ws != 4'hD
                 && !(shReg.ctrlA[7:6] == OM_TOGGLE && pwm && !ws[3]);
  assign connB = shReg.ctrlA[5:4] != OM_OFF && ws != 4'hD
                 && !(shReg.ctrlA[5:4] == OM_TOGGLE && pwm);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  oe_follow_a: assert property (
    settled |-> {pinOeA, pinOeB} == $past({portDirA, portDirB}))
    else $error("Pin enable differs from the direction bit.");
  a_port_level_a: assert property (
    settled && !$past(connA) |-> pinOutA == $past(portOutA))
    else $error("Pin A left the port level while disconnected.");
  a_wave_level_a: assert property (
    settled && $past(connA) |-> pinOutA == waveOutA)
    else $error("Pin A does not show its waveform.");
  b_port_level_a: assert property (
    settled && !$past(connB) |-> pinOutB == $past(portOutB))
    else $error("Pin B left the port level while disconnected.");
  b_wave_level_a: assert property (
    settled && $past(connB) |-> pinOutB == waveOutB)
    else $error("Pin B does not show its waveform.");
  reserved_flag_a: assert property (
    ws == 4'hD |=> !$rose(overflowFlag))
    else $error("Overflow set in the reserved mode.");
  ctrl_a_read_a: assert property (
    ioRead && ioAddr == ADDR_CTRL_A |=> ioRdData == shReg.ctrlA)
    else $error("Control A readback is wrong.");
  ctrl_b_read_a: assert property (
    ioRead && ioAddr == ADDR_CTRL_B ##1 1'b1 |-> ioRdData == $past(shNext.ctrlB))
    else $error("Control B readback is wrong.");
  flag_read_a: assert property (
    ioRead && ioAddr == ADDR_FLAGS |=> ioRdData[0] == $past(overflowFlag))
    else $error("Flag readback differs from the flag.");
endmodule

bind timer16_wave_mode_control timer16_wave_chk chk (
  .clk(clk), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrData(ioWrData), .ioWrite(ioWrite),
  .ioRead(ioRead), .ioRdData(ioRdData), .portOutA(portOutA), .portDirA(portDirA),
  .portOutB(portOutB), .portDirB(portDirB), .pinOutA(pinOutA), .pinOeA(pinOeA),
  .pinOutB(pinOutB), .pinOeB(pinOeB), .waveOutA(waveOutA), .waveOutB(waveOutB),
  .overflowFlag(overflowFlag));

// >>> tb_timer16_wave_mode_control.sv
// Self-checking bench: a CPU bus model drives the timer and the waveforms are judged.
`timescale 1ns/1ns
module tb_timer16_wave_mode_control
  import timer16_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  ioAddr;
  logic [7:0]  ioWrData;
  logic        ioWrite;
  logic        ioRead;
  logic [7:0]  ioRdData;
  logic        portOutA = 1'b0;
  logic        portDirA = 1'b0;
  logic        portOutB = 1'b0;
  logic        portDirB = 1'b0;
  logic        pinOutA, pinOeA, pinOutB, pinOeB, waveOutA, waveOutB, overflowFlag;
  logic [7:0]  rb;
  logic [15:0] rw;
  int          mismatches = 0;
  int          nTests = 0;
  int          cycles = 0;
  int          hiA, hiB, edA;

  timer16_wave_mode_control uut (
    .clk(clk), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrData(ioWrData), .ioWrite(ioWrite),
    .ioRead(ioRead), .ioRdData(ioRdData), .portOutA(portOutA), .portDirA(portDirA),
    .portOutB(portOutB), .portDirB(portDirB), .pinOutA(pinOutA), .pinOeA(pinOeA),
    .pinOutB(pinOutB), .pinOeB(pinOeB), .waveOutA(waveOutA), .waveOutB(waveOutB),
    .overflowFlag(overflowFlag));
  cpu_bus_model cpu (
    .clk(clk), .ioAddr(ioAddr), .ioWrData(ioWrData), .ioWrite(ioWrite),
    .ioRead(ioRead), .ioRdData(ioRdData));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic endOfTest();
    $display("Comparisons %0d, mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The whole run needs about four thousand cycles; a hang is cut well above that.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      endOfTest();
    end
  end

  task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkCnt(input int got, input int exp);
    nTests++;
    if (got != exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Port levels and directions keep moving so that pin ownership is visible.
  task automatic watch(input int n);
    logic prevA;
    hiA = 0;
    hiB = 0;
    edA = 0;
    @(negedge clk);
    prevA = waveOutA;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      {portDirB, portDirA, portOutB, portOutA} = i[3:0];
      hiA += int'(waveOutA === 1'b1);
      hiB += int'(waveOutB === 1'b1);
      edA += int'(waveOutA !== prevA);
      prevA = waveOutA;
    end
  endtask

  // Stopping in normal mode first makes the compare writes land at once.
  task automatic cfg(input logic [7:0] ca, input logic [7:0] cb,
                     input logic [15:0] ma, input logic [15:0] mb);
    cpu.wr(ADDR_CTRL_B, 8'h00);
    cpu.wr(ADDR_CTRL_A, 8'h00);
    cpu.wr16(ADDR_CMPA_L, ma);
    cpu.wr16(ADDR_CMPB_L, mb);
    cpu.wr16(ADDR_CNT_L, 16'h0000);
    cpu.wr(ADDR_CTRL_A, ca);
    cpu.wr(ADDR_CTRL_B, cb);
  endtask

  task automatic t_regs();
    cpu.rd(ADDR_CTRL_A, rb);
    chkVal({8'h00, rb}, {8'h00, CTRL_A_RESET});
    cpu.wr(ADDR_CTRL_B, 8'hFF);
    cpu.rd(ADDR_CTRL_B, rb);
    chkVal({8'h00, rb}, {8'h00, CTRL_B_MASK});
    cpu.wr(ADDR_CTRL_B, 8'h00);
    cpu.wr16(ADDR_CMPA_L, 16'h1234);
    cpu.wr(ADDR_CMPB_L, 8'h56);
    cpu.rd16(ADDR_CMPB_L, rw);
    chkVal(rw, 16'h1256);
    cpu.wr16(ADDR_CNT_L, 16'h01FF);
    cpu.wr(ADDR_CAP_H, 8'hAB);
    cpu.rd16(ADDR_CNT_L, rw);
    chkVal(rw, 16'h01FF);
    cpu.wr(ADDR_CMPA_H, 8'h77);
    cpu.rd(ADDR_CMPA_H, rb);
    chkVal({8'h00, rb}, 16'h0012);
    cpu.rd(ADDR_CNT_H, rb);
    chkVal({8'h00, rb}, 16'h0077);
    cpu.rd(6'h00, rb);
    chkVal({8'h00, rb}, 16'h0000);
    $display("register access test done");
  endtask

  task automatic t_clear();
    cfg(8'h70, 8'h09, 16'h0005, 16'h0003);
    watch(12);
    watch(60);
    chkCnt(edA, 10);
    chkCnt(hiB, 60);
    cpu.wr(ADDR_CTRL_A, 8'h60);
    watch(12);
    watch(60);
    chkCnt(hiB, 0);
    chkVal({15'h0000, overflowFlag}, 16'h0000);
    $display("compare clear test done");
  endtask

  task automatic t_flags();
    cfg(8'h00, 8'h01, 16'h0000, 16'h0000);
    cpu.wr16(ADDR_CNT_L, 16'hFFF0);
    watch(20);
    cpu.rd(ADDR_FLAGS, rb);
    chkVal({8'h00, rb & 8'h01}, 16'h0001);
    cpu.wr(ADDR_CTRL_B, 8'h00);
    cpu.wr(ADDR_FLAGS, 8'h01);
    chkVal({15'h0000, overflowFlag}, 16'h0000);
    cfg(8'hF1, 8'h19, 16'h0000, 16'h0000);
    cpu.wr16(ADDR_CNT_L, 16'hFFF0);
    watch(30);
    chkVal({15'h0000, overflowFlag}, 16'h0000);
    $display("overflow flag test done");
  endtask

  task automatic t_pwm();
    cfg(8'hB1, 8'h09, 16'h0040, 16'h0040);
    watch(300);
    watch(256);
    chkCnt(hiA, 64);
    chkCnt(hiB, 192);
    cfg(8'hB1, 8'h09, 16'h00FF, 16'h00FF);
    watch(300);
    watch(256);
    chkCnt(hiA, 256);
    chkCnt(hiB, 0);
    cfg(8'hB1, 8'h01, 16'h0040, 16'h0040);
    watch(600);
    watch(510);
    chkCnt(hiA, 128);
    chkCnt(hiB, 382);
    cfg(8'h21, 8'h11, 16'h0080, 16'h0020);
    watch(600);
    watch(256);
    chkCnt(hiB, 64);
    $display("pwm shape test done");
  endtask

  task automatic t_toggle();
    cfg(8'h53, 8'h19, 16'h0009, 16'h0003);
    watch(20);
    watch(100);
    chkCnt(edA, 10);
    cpu.wr(ADDR_CTRL_A, 8'h51);
    cpu.wr(ADDR_CTRL_B, 8'h09);
    watch(300);
    chkCnt(edA, 0);
    $display("pwm toggle test done");
  endtask

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_clear();
    t_flags();
    t_pwm();
    t_toggle();
    endOfTest();
  end
endmodule
